//--- rtc_pkg.sv
/*
 * Shared constants of the binary real-time clock: register byte offsets,
 * control field positions, reset values and the tick timing.
 * Assumes a 40 MHz system clock and a 32.768 kHz oscillator input.
 */
`default_nettype none

package rtc_pkg;

	// Register byte offsets, one aligned 32-bit word each.
	localparam logic [4:0] OFF_CONTROL = 5'h00;
	localparam logic [4:0] OFF_SEC_HIGH = 5'h04;
	localparam logic [4:0] OFF_SEC_LOW = 5'h08;
	localparam logic [4:0] OFF_SUBSEC = 5'h0c;
	localparam logic [4:0] OFF_ALARM_HIGH = 5'h10;
	localparam logic [4:0] OFF_ALARM_LOW = 5'h14;
	localparam logic [4:0] OFF_SS_RELOAD = 5'h18;
	localparam logic [4:0] OFF_TRIM = 5'h1c;

	// Control register bit positions.
	localparam int CTL_ENABLE = 0;
	localparam int CTL_WRITABLE = 1;
	localparam int CTL_CLKSEL = 2;
	localparam int CTL_SQW_EN = 3;
	localparam int CTL_TOD_EN = 4;
	localparam int CTL_SS_EN = 5;
	localparam int CTL_TOD_FLAG = 6;
	localparam int CTL_SS_FLAG = 7;

	// Software-writable control bits, and reset values.
	localparam logic [15:0] CTL_RW_MASK = 16'h003d;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [31:0] SECONDS_RESET = 32'h0000_0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Timing: rates in hertz, cycle counts derived from them.
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_HZ = 256;
	localparam int OSC_HZ = 32_768;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int OSC_DIV = OSC_HZ / TICK_HZ;
	localparam logic [7:0] SUBSEC_MAX = 8'hff;

endpackage
`default_nettype wire

//--- rtc_tick_if.sv
/*
 * Carrier between the clock core and its 256 Hz tick generator.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface rtc_tick_if;
	logic run; // Clock enabled.
	logic useOsc; // Take ticks from the oscillator pin.
	logic oscEdge; // Synchronised rising edge of the oscillator.
	logic [7:0] trim; // Signed cycle correction per second.
	logic tick; // One-cycle 256 Hz tick.

	modport gen (input run, input useOsc, input oscEdge, input trim,
		output tick);
	modport core (output run, output useOsc, output oscEdge, output trim,
		input tick);
endinterface
`default_nettype wire

//--- rtc_tick_gen.sv
/*
 * Tick generator: one-cycle enable pulses at 256 Hz, either by dividing
 * the system clock with a once-per-second trim or by dividing the
 * synchronised oscillator edges. Assumes edges arrive already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

module rtc_tick_gen #(
	parameter int TickCycles = rtc_pkg::TICK_CYCLES
) (
	input wire logic ref_clk, // System clock.
	input wire logic rst_b, // Synchronous reset, active low.
	rtc_tick_if.gen tk // Control in, tick out.
);
	localparam int CW = $clog2(TickCycles + 256);

	logic [CW-1:0] cntReg;
	logic [7:0] idxReg;
	logic [6:0] oscCntReg;
	logic [CW-1:0] limit;
	logic intTick;
	logic oscTick;

	// The trim acts on one tick in 256, so a second stretches or shrinks
	// by trim cycles while every other tick keeps its nominal length.
	always_comb begin
		if (idxReg == 8'h00) begin
			limit = CW'(TickCycles - 1 + int'($signed(tk.trim)));
		end else begin
			limit = CW'(TickCycles - 1);
		end
	end

	assign intTick = (cntReg >= limit);
	assign oscTick = tk.oscEdge && (oscCntReg == 7'(rtc_pkg::OSC_DIV - 1));
	assign tk.tick = tk.run && (tk.useOsc ? oscTick : intTick);

	// System clock divider; held cleared while the clock is stopped.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !tk.run || tk.useOsc) begin
			cntReg <= '0;
		end else if (intTick) begin
			cntReg <= '0;
		end else begin
			cntReg <= cntReg + 1'b1;
		end
	end

	// Position within the second, selecting which tick gets the trim.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !tk.run) begin
			idxReg <= 8'h00;
		end else if (tk.tick) begin
			idxReg <= idxReg + 8'h01;
		end
	end

	// Oscillator edge divider.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !tk.run || !tk.useOsc) begin
			oscCntReg <= 7'h00;
		end else if (tk.oscEdge) begin
			oscCntReg <= oscCntReg + 7'h01;
		end
	end
endmodule // rtc_tick_gen
`default_nettype wire

//--- binary_rtc_with_alarms.sv
/*
 * Binary real-time clock with an 8-bit sub-second and a 32-bit seconds
 * counter, an auto-reload interval alarm and a one-shot time-of-day alarm,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes a 40 MHz ref_clk and an asynchronous 32.768 kHz oscillator pin.
 */
`timescale 1ns/1ps
`default_nettype none

module binary_rtc_with_alarms #(
	parameter int TickCycles = rtc_pkg::TICK_CYCLES
) (
	input wire logic ref_clk, // System clock, 40 MHz.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic [4:0] avs_address, // Byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	input wire logic [3:0] avs_byteenable, // Write byte lanes.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall while the answer is prepared.
	input wire logic oscPin, // 32.768 kHz oscillator, asynchronous.
	output logic sqwOut, // 1 Hz square wave when enabled.
	output logic todIrq, // Time-of-day alarm request.
	output logic subIrq // Interval alarm request.
);
	logic ackReg;
	logic wrEn;
	logic [15:0] controlReg;
	logic todFlagReg;
	logic ssFlagReg;
	logic [31:0] secondsReg;
	logic [7:0] subReg;
	logic [31:0] alarmReg;
	logic [7:0] reloadReg;
	logic [7:0] alarmCntReg;
	logic [7:0] trimReg;
	logic [31:0] readNext;
	logic oscMeta;
	logic oscSync;
	logic oscPrev;
	logic running;
	logic tick;
	logic secInc;
	logic todEvent;
	logic ssEvent;
	logic frozen;
	logic ctlWr;
	rtc_tick_if tk ();

	// Merge a 16-bit field with the enabled byte lanes of the write data.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] data, input logic [1:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = data[7:0];
		end
		if (be[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// One wait state: the answer is ready on the second request cycle.
	assign avs_waitrequest = (avs_read || avs_write) && !ackReg;
	assign wrEn = avs_write && ackReg;
	assign ctlWr = wrEn && (avs_address == rtc_pkg::OFF_CONTROL);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ackReg <= 1'b0;
		end else begin
			ackReg <= (avs_read || avs_write) && !ackReg;
		end
	end

	// Oscillator pin synchroniser; only the second and third stages feed logic.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			oscMeta <= 1'b0;
			oscSync <= 1'b0;
			oscPrev <= 1'b0;
		end else begin
			oscMeta <= oscPin;
			oscSync <= oscMeta;
			oscPrev <= oscSync;
		end
	end

	assign running = controlReg[rtc_pkg::CTL_ENABLE];
	assign frozen = !running;
	assign tk.run = running;
	assign tk.useOsc = controlReg[rtc_pkg::CTL_CLKSEL];
	assign tk.oscEdge = oscSync && !oscPrev;
	assign tk.trim = trimReg;
	assign tick = tk.tick;

	rtc_tick_gen #(
		.TickCycles(TickCycles)
	) u_tick (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tk(tk)
	);

	// Control configuration bits; the flags live in their own registers.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			controlReg <= rtc_pkg::CONTROL_RESET;
		end else if (ctlWr) begin
			controlReg <= merge16(controlReg, avs_writedata[15:0],
				avs_byteenable[1:0]) & rtc_pkg::CTL_RW_MASK;
		end
	end

	// Sub-second counter: counts ticks while running, loadable when stopped.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			subReg <= rtc_pkg::BYTE_RESET;
		end else if (running && tick) begin
			subReg <= subReg + 8'h01;
		end else if (frozen && wrEn && avs_byteenable[0] &&
			avs_address == rtc_pkg::OFF_SUBSEC) begin
			subReg <= avs_writedata[7:0];
		end
	end

	// Seconds advance on each sub-second wrap.
	assign secInc = running && tick && (subReg == rtc_pkg::SUBSEC_MAX);

	// Seconds counter. Loads while running are ignored, because a load
	// racing a carry would leave the two halves inconsistent.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			secondsReg <= rtc_pkg::SECONDS_RESET;
		end else if (secInc) begin
			secondsReg <= secondsReg + 32'h0000_0001;
		end else if (frozen && wrEn) begin
			if (avs_address == rtc_pkg::OFF_SEC_HIGH) begin
				secondsReg[31:16] <= merge16(secondsReg[31:16],
					avs_writedata[15:0], avs_byteenable[1:0]);
			end else if (avs_address == rtc_pkg::OFF_SEC_LOW) begin
				secondsReg[15:0] <= merge16(secondsReg[15:0],
					avs_writedata[15:0], avs_byteenable[1:0]);
			end
		end
	end

	// Alarm value, reload and trim registers; always writable.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			alarmReg <= rtc_pkg::SECONDS_RESET;
			reloadReg <= rtc_pkg::BYTE_RESET;
			trimReg <= rtc_pkg::BYTE_RESET;
		end else if (wrEn) begin
			case (avs_address)
			rtc_pkg::OFF_ALARM_HIGH: begin
				alarmReg[31:16] <= merge16(alarmReg[31:16],
					avs_writedata[15:0], avs_byteenable[1:0]);
			end
			rtc_pkg::OFF_ALARM_LOW: begin
				alarmReg[15:0] <= merge16(alarmReg[15:0],
					avs_writedata[15:0], avs_byteenable[1:0]);
			end
			rtc_pkg::OFF_SS_RELOAD: begin
				if (avs_byteenable[0]) begin
					reloadReg <= avs_writedata[7:0];
				end
			end
			rtc_pkg::OFF_TRIM: begin
				if (avs_byteenable[0]) begin
					trimReg <= avs_writedata[7:0];
				end
			end
			default: begin
			end
			endcase
		end
	end

	// Interval alarm: fires every reload+1 ticks, then reloads itself.
	assign ssEvent = running && controlReg[rtc_pkg::CTL_SS_EN] && tick &&
		(alarmCntReg == 8'h00);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			alarmCntReg <= rtc_pkg::BYTE_RESET;
		end else if (!controlReg[rtc_pkg::CTL_SS_EN]) begin
			alarmCntReg <= reloadReg;
		end else if (ssEvent) begin
			alarmCntReg <= reloadReg;
		end else if (running && tick) begin
			alarmCntReg <= alarmCntReg - 8'h01;
		end
	end

	// Time-of-day alarm: one event on the increment that reaches the value.
	assign todEvent = secInc && controlReg[rtc_pkg::CTL_TOD_EN] &&
		(secondsReg + 32'h0000_0001 == alarmReg);

	// Sticky flags, cleared by writing one; a new event beats the clear.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			todFlagReg <= 1'b0;
			ssFlagReg <= 1'b0;
		end else begin
			if (todEvent) begin
				todFlagReg <= 1'b1;
			end else if (ctlWr && avs_byteenable[0] &&
				avs_writedata[rtc_pkg::CTL_TOD_FLAG]) begin
				todFlagReg <= 1'b0;
			end
			if (ssEvent) begin
				ssFlagReg <= 1'b1;
			end else if (ctlWr && avs_byteenable[0] &&
				avs_writedata[rtc_pkg::CTL_SS_FLAG]) begin
				ssFlagReg <= 1'b0;
			end
		end
	end

	assign todIrq = todFlagReg && controlReg[rtc_pkg::CTL_TOD_EN];
	assign subIrq = ssFlagReg && controlReg[rtc_pkg::CTL_SS_EN];
	assign sqwOut = controlReg[rtc_pkg::CTL_SQW_EN] && running && subReg[7];

	// Read multiplexer; live counters are sampled without stalling them.
	always_comb begin
		readNext = 32'h0000_0000;
		case (avs_address)
		rtc_pkg::OFF_CONTROL: begin
			readNext[15:0] = controlReg;
			readNext[rtc_pkg::CTL_WRITABLE] = frozen;
			readNext[rtc_pkg::CTL_TOD_FLAG] = todFlagReg;
			readNext[rtc_pkg::CTL_SS_FLAG] = ssFlagReg;
		end
		rtc_pkg::OFF_SEC_HIGH: readNext[15:0] = secondsReg[31:16];
		rtc_pkg::OFF_SEC_LOW: readNext[15:0] = secondsReg[15:0];
		rtc_pkg::OFF_SUBSEC: readNext[7:0] = subReg;
		rtc_pkg::OFF_ALARM_HIGH: readNext[15:0] = alarmReg[31:16];
		rtc_pkg::OFF_ALARM_LOW: readNext[15:0] = alarmReg[15:0];
		rtc_pkg::OFF_SS_RELOAD: readNext[7:0] = reloadReg;
		rtc_pkg::OFF_TRIM: readNext[7:0] = trimReg;
		default: readNext = 32'h0000_0000;
		endcase
	end

	// Read data is captured while waitrequest is high and stands after.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ackReg) begin
			avs_readdata <= readNext;
		end
	end

	// Checks kept next to the logic they guard.
	property p_sub_step;
		@(posedge ref_clk) disable iff (!rst_b)
		(running && tick) |=> (subReg == $past(subReg) + 8'h01);
	endproperty
	a_sub_step: assert property (p_sub_step)
		else $error("Sub-second counter did not step on a tick.");

	property p_sec_carry;
		@(posedge ref_clk) disable iff (!rst_b)
		(running && tick && subReg == 8'hff) |=>
			(subReg == 8'h00) && (secondsReg == $past(secondsReg) + 1);
	endproperty
	a_sec_carry: assert property (p_sec_carry)
		else $error("Seconds did not advance on sub-second wrap.");

	property p_count_steady;
		@(posedge ref_clk) disable iff (!rst_b)
		(running && !tick) |=> $stable(secondsReg) && $stable(subReg);
	endproperty
	a_count_steady: assert property (p_count_steady)
		else $error("Counters moved without a tick while running.");

	property p_ss_reload;
		@(posedge ref_clk) disable iff (!rst_b)
		ssEvent |=> (alarmCntReg == $past(reloadReg)) && ssFlagReg;
	endproperty
	a_ss_reload: assert property (p_ss_reload)
		else $error("Interval alarm did not reload or flag.");

	property p_tod_hit;
		@(posedge ref_clk) disable iff (!rst_b)
		(secInc && controlReg[rtc_pkg::CTL_TOD_EN] &&
			secondsReg + 1 == alarmReg) |=>
			todFlagReg && (secondsReg == alarmReg);
	endproperty
	a_tod_hit: assert property (p_tod_hit)
		else $error("Time-of-day match did not raise its flag.");

	property p_sec_load;
		@(posedge ref_clk) disable iff (!rst_b)
		(frozen && wrEn && avs_address == rtc_pkg::OFF_SEC_LOW &&
			avs_byteenable == 4'hf)
			|=> (secondsReg[15:0] == $past(avs_writedata[15:0]));
	endproperty
	a_sec_load: assert property (p_sec_load)
		else $error("Stopped seconds low half did not load.");

	property p_flag_sticky;
		@(posedge ref_clk) disable iff (!rst_b)
		(todFlagReg && !ctlWr) |=> todFlagReg;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("Alarm flag dropped without a clear.");

	property p_one_wait;
		@(posedge ref_clk) disable iff (!rst_b)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("Bus request stalled for more than one cycle.");
endmodule // binary_rtc_with_alarms
`default_nettype wire

//--- tb_top.sv
/*
 * Self-checking bench of the binary real-time clock: register access over
 * Avalon-MM, counting, carries, alarms, trim and the square wave.
 * Assumes the design package and a small TickCycles for a short run.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int TC = 20;
	localparam int LIMIT = 40000;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic oscPin = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sqwOut;
	logic todIrq;
	logic subIrq;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int t0;
	int t1;
	logic [31:0] rd;
	logic [31:0] rd2;
	logic [4:0] tAddr [4] = '{5'h10, 5'h14, 5'h18, 5'h1c};
	logic [31:0] tData [4] = '{32'hffff, 32'ha5a5, 32'h01ff, 32'h01ff};
	logic [31:0] tExp [4] = '{32'hffff, 32'ha5a5, 32'h00ff, 32'h00ff};

	binary_rtc_with_alarms #(.TickCycles(TC)) i_dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.oscPin(oscPin),
		.sqwOut(sqwOut),
		.todIrq(todIrq),
		.subIrq(subIrq)
	);

	// Free-running clock at 40 MHz.
	always #12.5 ref_clk = ~ref_clk;

	// Cycle count for interval measurement and the hang limit. The
	// oscillator stand-in toggles every two cycles, far faster than a real
	// crystal, so the oscillator scenario stays short.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		oscPin <= cyc[1];
		if (cyc == LIMIT) begin
			errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chkVal(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Durations may land one tick either way where the phase is free.
	task automatic chkCyc(input string nm, input int e, input int g,
		input int tol);
		n_tests++;
		if (g < e - tol || g > e + tol) begin
			errors++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// A request is held until waitrequest is sampled low at a rising edge.
	task automatic busRead(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task automatic busWrite(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic rdChk(input string nm, input logic [4:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		busRead(a, d);
		chkVal(nm, e, d);
	endtask

	task automatic waitIrq(input bit tod);
		do @(posedge ref_clk); while ((tod ? todIrq : subIrq) !== 1'b1);
	endtask

	// Main sequence: reset, then one scenario after another.
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdChk("control", 5'h00, 32'h0002);
		rdChk("secHigh", 5'h04, 32'h0000);
		rdChk("secLow", 5'h08, 32'h0000);
		rdChk("subsec", 5'h0c, 32'h0000);
		busWrite(5'h02, 32'hffff);
		rdChk("unmapped", 5'h02, 32'h0000);
		busWrite(5'h00, 32'hffff);
		rdChk("controlAll", 5'h00, 32'h003d);
		busWrite(5'h00, 32'h0000);
		rdChk("controlOff", 5'h00, 32'h0002);
		for (int i = 0; i < 4; i++) begin
			busWrite(tAddr[i], tData[i]);
			rdChk("alarmRegs", tAddr[i], tExp[i]);
		end
		busWrite(5'h1c, 32'h0000);
		// Load while stopped, then a carry across both seconds halves.
		busWrite(5'h04, 32'h0001);
		busWrite(5'h08, 32'hffff);
		busWrite(5'h0c, 32'h00fe);
		rdChk("secLowLoad", 5'h08, 32'hffff);
		rdChk("subsecLoad", 5'h0c, 32'h00fe);
		busWrite(5'h00, 32'h0001);
		rdChk("controlRun", 5'h00, 32'h0001);
		busWrite(5'h08, 32'h1234);
		repeat (5 * TC) @(posedge ref_clk);
		busWrite(5'h00, 32'h0000);
		rdChk("secHighCarry", 5'h04, 32'h0002);
		rdChk("secLowRefused", 5'h08, 32'h0000);
		// Tick rate measured while reads run back to back.
		busWrite(5'h0c, 32'h0000);
		busWrite(5'h00, 32'h0001);
		busRead(5'h0c, rd);
		t0 = cyc;
		while (cyc - t0 < 100 * TC) busRead(5'h08, rd2);
		busRead(5'h0c, rd2);
		t1 = cyc;
		chkCyc("tickCount", (t1 - t0) / TC, int'(rd2[7:0] - rd[7:0]), 1);
		busWrite(5'h00, 32'h0000);
		// One-shot time-of-day alarm, masking and clearing.
		busWrite(5'h04, 32'h0000);
		busWrite(5'h08, 32'h0005);
		busWrite(5'h0c, 32'h00f0);
		busWrite(5'h10, 32'h0000);
		busWrite(5'h14, 32'h0006);
		busWrite(5'h00, 32'h0011);
		waitIrq(1'b1);
		rdChk("todFlag", 5'h00, 32'h0051);
		rdChk("todSeconds", 5'h08, 32'h0006);
		busWrite(5'h00, 32'h0001);
		@(posedge ref_clk);
		chkVal("todMasked", 32'h0, {31'h0, todIrq});
		rdChk("todSticky", 5'h00, 32'h0041);
		busWrite(5'h00, 32'h0041);
		rdChk("todCleared", 5'h00, 32'h0001);
		busWrite(5'h00, 32'h0000);
		// Interval alarm repeats every reload plus one ticks.
		busWrite(5'h18, 32'h0009);
		busWrite(5'h00, 32'h0021);
		waitIrq(1'b0);
		t0 = cyc;
		busWrite(5'h00, 32'h00a1);
		@(posedge ref_clk);
		chkVal("subCleared", 32'h0, {31'h0, subIrq});
		waitIrq(1'b0);
		t1 = cyc;
		chkCyc("intervalPeriod", 10 * TC, t1 - t0, 0);
		rdChk("subFlag", 5'h00, 32'h00a1);
		busWrite(5'h00, 32'h0080);
		rdChk("subOff", 5'h00, 32'h0002);
		// Trim stretches one second, seen on the square wave.
		busWrite(5'h1c, 32'h000a);
		busWrite(5'h0c, 32'h0000);
		busWrite(5'h00, 32'h0009);
		while (sqwOut !== 1'b1) @(posedge ref_clk);
		t0 = cyc;
		while (sqwOut !== 1'b0) @(posedge ref_clk);
		while (sqwOut !== 1'b1) @(posedge ref_clk);
		t1 = cyc;
		chkCyc("trimSecond", 256 * TC + 10, t1 - t0, 0);
		busWrite(5'h00, 32'h0000);
		@(posedge ref_clk);
		chkVal("sqwStopped", 32'h0, {31'h0, sqwOut});
		// Oscillator source: one tick per 128 pin edges, pin period 4.
		busWrite(5'h0c, 32'h0000);
		busWrite(5'h00, 32'h0005);
		repeat (3 * 128 * 4) @(posedge ref_clk);
		rdChk("controlOsc", 5'h00, 32'h0005);
		busRead(5'h0c, rd);
		chkCyc("oscTicks", 3, int'(rd[7:0]), 1);
		busWrite(5'h00, 32'h0000);
		// Byte lanes: only the low byte of the alarm low half changes.
		avs_byteenable <= 4'h1;
		busWrite(5'h14, 32'h1234);
		avs_byteenable <= 4'hf;
		rdChk("alarmLowByte", 5'h14, 32'h0034);
		// Reset in mid-run returns the registers to their reset values.
		busWrite(5'h00, 32'h0001);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdChk("controlReset", 5'h00, 32'h0002);
		rdChk("subsecReset", 5'h0c, 32'h0000);
		rdChk("trimReset", 5'h1c, 32'h0000);
		conclude();
	end
endmodule // tb_top
`default_nettype wire
